// [rtl/dvs_volume_top.sv]
// Purpose: stereo digital playback volume with soft-stepping and pin control
// Assumes: page 0 selected, samples arrive as left/right pairs
// Notes:   dB to linear uses a piecewise-linear mantissa, error under 0.6 dB
// Overview of operation
// R1 - per-channel gain +24 to -63.5 dB, 0.5 dB
// R2 - left gain reg 0x41, right 0x42
// R3 - reg 0x40 low bits: mutes and master
// R4 - soft step 0.125 dB per sample
// R5 - reg 0x3f can halve step rate
// R6 - reg 0x3f can disable soft stepping
// R7 - pin control only when reg 0x74 bit7
// R8 - reg 0x26 bits 4/0 report settled
// R9 - host keeps clock until stepping ends
// R10 - 7-bit SAR result overwrites gain settings
// R11 - last pin setting readable at 0x75
// R12 - reg 0x74 bit6 picks SAR clock
// R13 - reg 0x74 bits 2:0 set update rate
// R14 - pin code to gain map, 127 mutes
// R15 - filter A: 48 ksps, 21 delay
// R16 - filter B: 96 ksps, 18 delay
// R17 - filter C: 192 ksps, 13 delay
// R18 - gain register is signed half-dB count
`timescale 1ns/10ps
module dvs_volume_top
    import dvs_pkg::*;
#(
    parameter int SAMPLE_W = 16,
    parameter int BUF_DEPTH = 2
) (
    input  wire logic                clk_sys_in,
    input  wire logic                reset_n_in,
    input  wire logic [7:0]          reg_addr_in,
    input  wire logic                reg_wr_in,
    input  wire logic [7:0]          reg_wdata_in,
    input  wire logic                reg_rd_in,
    output logic [7:0]               reg_rdata_out,
    input  wire logic                smp_valid_in,
    input  wire logic [SAMPLE_W-1:0] smp_left_in,
    input  wire logic [SAMPLE_W-1:0] smp_right_in,
    output logic                     smp_ready_out,
    output logic                     vol_valid_out,
    output logic [SAMPLE_W-1:0]      vol_left_out,
    output logic [SAMPLE_W-1:0]      vol_right_out,
    input  wire logic                vol_ready_in,
    input  wire logic                volume_sense_cmp_in,
    output logic [6:0]               volume_sense_trial_out,
    output logic                     volume_sense_hold_out,
    input  wire logic [1:0]          interp_sel_in,
    output logic [4:0]               group_delay_out,
    output logic [7:0]               max_rate_ksps_out
);
    typedef struct packed {
        logic [1:0]        step_ctrl;
        logic [3:0]        mute_ctrl;
        logic [7:0]        gain_l;
        logic [7:0]        gain_r;
        logic              pin_en;
        logic              pin_clk_sel;
        logic [2:0]        pin_rate;
        logic [6:0]        pin_code;
        logic signed [9:0] appl_l;
        logic signed [9:0] appl_r;
        logic              half_phase;
        logic [7:0]        rdata;
        logic [2:0]        cmp_sync;
        logic              cmp_val;
        logic [7:0]        sar_div;
        logic [15:0]       rate_cnt;
        dvs_sar_t          sar_state;
        logic [2:0]        sar_bit;
        logic [6:0]        trial;
        logic              hold;
        logic [4:0]        delay;
        logic [7:0]        ksps;
    } dvs_state_t;

    dvs_state_t s_reg, s_next;
    logic [1:0] rst_sync_reg;
    logic       rst_n;
    logic       buf_ready;
    logic       smp_tick;
    logic       buf_valid;
    logic [2*SAMPLE_W-1:0] buf_data;

    // half-dB count, clamped at +24 dB; 0x80 and mute both mean silence
    function automatic logic signed [9:0] target_q(input logic [7:0] g, input logic mute);
        logic signed [7:0] sg;
        sg = $signed(g);
        if (mute || g == MUTE_SETTING) return MUTE_Q;
        if (sg > GAIN_MAX_HALF) sg = GAIN_MAX_HALF; // [R1]
        return $signed({sg, 2'b00}); // [R18]
    endfunction

    function automatic logic signed [9:0] step_q(input logic signed [9:0] a,
                                                 input logic signed [9:0] t,
                                                 input logic en, input logic off);
        if (off) return t; // [R6]
        if (en && a < t) return a + 10'sh001; // [R4]
        if (en && a > t) return a - 10'sh001; // [R4]
        return a;
    endfunction

    // 6 dB per octave approximation keeps the table out of the design
    function automatic logic [SAMPLE_W-1:0] apply_gain(input logic [SAMPLE_W-1:0] x,
                                                       input logic signed [9:0] q);
        logic [10:0] qo;
        logic [3:0]  oct;
        logic [5:0]  frac;
        logic [16:0] mant;
        logic signed [47:0] p;
        logic [4:0]  sh;
        logic signed [47:0] y;
        qo = 11'($signed({q[9], q}) + 11'(Q_OFFSET));
        oct = 4'(qo / 11'(Q_PER_OCT));
        frac = 6'(qo % 11'(Q_PER_OCT));
        mant = 17'(MANT_ONE) + 17'(frac * 17'(MANT_SLOPE));
        p = 48'($signed(x) * $signed({1'b0, mant}));
        sh = 5'(SHIFT_BASE) - 5'(oct);
        y = p >>> sh;
        if (q <= MUTE_Q) return '0;
        if (y > 48'sh7fff) return 16'h7fff;
        if (y < -48'sh8000) return 16'h8000;
        return y[SAMPLE_W-1:0];
    endfunction

    function automatic logic [7:0] pin_to_gain(input logic [6:0] c);
        if (c == PIN_MUTE_CODE) return MUTE_SETTING; // [R14]
        if (c <= PIN_LIN_LAST) return 8'(PIN_TOP_HALF - $signed({1'b0, c})); // [R14]
        return 8'(PIN_BRK_HALF - $signed({1'b0, c - PIN_BRK_CODE, 1'b0})); // [R14]
    endfunction

    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) rst_sync_reg <= 2'h0;
        else rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
    assign rst_n = rst_sync_reg[1];

    // a sample is consumed only when the buffer can take it
    assign smp_tick = smp_valid_in & buf_ready;

    always_comb begin
        logic [7:0] eff_gl;
        logic [7:0] eff_gr;
        logic       eff_ml;
        logic       eff_mr;
        logic signed [9:0] tgt_l;
        logic signed [9:0] tgt_r;
        logic       step_en;
        logic       step_off;
        logic       sar_tick;
        logic [6:0] decided;
        eff_gl = s_reg.gain_l;
        eff_gr = s_reg.gain_r;
        eff_ml = s_reg.mute_ctrl[MUTE_L_BIT];
        eff_mr = s_reg.mute_ctrl[MUTE_R_BIT];
        tgt_l = '0;
        tgt_r = '0;
        step_en = 1'b0;
        step_off = 1'b0;
        sar_tick = 1'b0;
        decided = '0;
        s_next = s_reg;

        // host writes
        if (reg_wr_in) begin
            case (reg_addr_in)
                ADDR_STEP:     s_next.step_ctrl = reg_wdata_in[1:0]; // [R5] [R6]
                ADDR_MUTE:     s_next.mute_ctrl = reg_wdata_in[3:0]; // [R3]
                ADDR_GAIN_L:   s_next.gain_l = reg_wdata_in; // [R2]
                ADDR_GAIN_R:   s_next.gain_r = reg_wdata_in; // [R2]
                ADDR_PIN_CTRL: begin
                    s_next.pin_en = reg_wdata_in[PIN_EN_BIT]; // [R7]
                    s_next.pin_clk_sel = reg_wdata_in[PIN_CLK_BIT]; // [R12]
                    s_next.pin_rate = reg_wdata_in[2:0]; // [R13]
                end
                default: ;
            endcase
        end

        // master mode lets one channel's setting govern both
        case (s_reg.mute_ctrl[1:0])
            MASTER_FROM_L: begin
                eff_gr = s_reg.gain_l; // [R3]
                eff_mr = eff_ml;
            end
            MASTER_FROM_R: begin
                eff_gl = s_reg.gain_r; // [R3]
                eff_ml = eff_mr;
            end
            default: ;
        endcase
        tgt_l = target_q(eff_gl, eff_ml);
        tgt_r = target_q(eff_gr, eff_mr);

        // soft stepping
        step_off = s_reg.step_ctrl[1];
        if (smp_tick) begin
            s_next.half_phase = ~s_reg.half_phase;
        end
        step_en = smp_tick & ((s_reg.step_ctrl != STEP_HALF) | s_reg.half_phase); // [R5]
        s_next.appl_l = step_q(s_reg.appl_l, tgt_l, step_en, step_off);
        s_next.appl_r = step_q(s_reg.appl_r, tgt_r, step_en, step_off);

        // pin comparator: take a change once the last two stages agree
        s_next.cmp_sync = {s_reg.cmp_sync[1:0], volume_sense_cmp_in};
        if (s_reg.cmp_sync[1] == s_reg.cmp_sync[2]) begin
            s_next.cmp_val = s_reg.cmp_sync[2];
        end

        // converter clock: divided system clock or the sample rate
        s_next.sar_div = (s_reg.sar_div == 8'h00) ? 8'(SAR_DIV_CYCLES - 1) : s_reg.sar_div - 8'h01;
        sar_tick = s_reg.pin_clk_sel ? smp_tick : (s_reg.sar_div == 8'h00); // [R12]

        case (s_reg.sar_state)
            SAR_IDLE: begin
                s_next.hold = 1'b0;
                if (s_reg.pin_en && sar_tick) begin // [R7]
                    if (s_reg.rate_cnt == 16'h0000) begin
                        s_next.rate_cnt = 16'((RATE_BASE_TICKS << s_reg.pin_rate) - 1); // [R13]
                        s_next.sar_state = SAR_HOLD;
                        s_next.hold = 1'b1;
                    end else begin
                        s_next.rate_cnt = s_reg.rate_cnt - 16'h0001;
                    end
                end
            end
            SAR_HOLD: begin
                if (sar_tick) begin
                    s_next.hold = 1'b0;
                    s_next.trial = 7'h40;
                    s_next.sar_bit = 3'h6;
                    s_next.sar_state = SAR_CONV;
                end
            end
            SAR_CONV: begin
                if (sar_tick) begin
                    decided = s_reg.trial;
                    if (!s_reg.cmp_val) begin
                        decided[s_reg.sar_bit] = 1'b0; // [R10]
                    end
                    s_next.trial = decided;
                    if (s_reg.sar_bit == 3'h0) begin
                        s_next.sar_state = SAR_IDLE;
                        // a late disable drops the result
                        if (s_reg.pin_en) begin
                            s_next.pin_code = decided; // [R11]
                            s_next.gain_l = pin_to_gain(decided); // [R10]
                            s_next.gain_r = pin_to_gain(decided); // [R10]
                        end
                    end else begin
                        s_next.trial[s_reg.sar_bit - 3'h1] = 1'b1;
                        s_next.sar_bit = s_reg.sar_bit - 3'h1;
                    end
                end
            end
            default: s_next.sar_state = SAR_IDLE;
        endcase

        // register reads
        if (reg_rd_in) begin
            case (reg_addr_in)
                ADDR_SETTLED: begin
                    s_next.rdata = 8'h00;
                    s_next.rdata[SETTLED_L_BIT] = (s_reg.appl_l == tgt_l); // [R8]
                    s_next.rdata[SETTLED_R_BIT] = (s_reg.appl_r == tgt_r); // [R8]
                end
                ADDR_STEP:     s_next.rdata = {6'h00, s_reg.step_ctrl};
                ADDR_MUTE:     s_next.rdata = {4'h0, s_reg.mute_ctrl};
                ADDR_GAIN_L:   s_next.rdata = s_reg.gain_l;
                ADDR_GAIN_R:   s_next.rdata = s_reg.gain_r;
                ADDR_PIN_CTRL: s_next.rdata = {s_reg.pin_en, s_reg.pin_clk_sel, 3'h0, s_reg.pin_rate};
                ADDR_PIN_READ: s_next.rdata = {1'b0, s_reg.pin_code}; // [R11]
                default:       s_next.rdata = 8'h00;
            endcase
        end

        // interpolation filter limits for the selected option
        case (interp_sel_in)
            2'h0: begin
                s_next.delay = FILT_A_DELAY; // [R15]
                s_next.ksps = FILT_A_KSPS; // [R15]
            end
            2'h1: begin
                s_next.delay = FILT_B_DELAY; // [R16]
                s_next.ksps = FILT_B_KSPS; // [R16]
            end
            default: begin
                s_next.delay = FILT_C_DELAY; // [R17]
                s_next.ksps = FILT_C_KSPS; // [R17]
            end
        endcase
    end

    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            s_reg <= '0;
            s_reg.step_ctrl <= RST_STEP;
            s_reg.mute_ctrl <= RST_MUTE;
            s_reg.gain_l <= RST_GAIN;
            s_reg.gain_r <= RST_GAIN;
            s_reg.pin_en <= RST_PIN_CTRL[PIN_EN_BIT];
            s_reg.pin_code <= RST_PIN_CODE;
            s_reg.appl_l <= MUTE_Q;
            s_reg.appl_r <= MUTE_Q;
            s_reg.sar_state <= SAR_IDLE;
            s_reg.delay <= FILT_A_DELAY;
            s_reg.ksps <= FILT_A_KSPS;
        end else begin
            s_reg <= s_next;
        end
    end

    // gain is applied on the way into the buffer so a stall loses nothing
    dvs_pair_buf #(
        .WIDTH (2 * SAMPLE_W),
        .DEPTH (BUF_DEPTH)
    ) u_out_buf (
        .clk_in        (clk_sys_in),
        .rst_n_in      (rst_n),
        .in_valid_in   (smp_valid_in),
        .in_data_in    ({apply_gain(smp_left_in, s_reg.appl_l), apply_gain(smp_right_in, s_reg.appl_r)}),
        .in_ready_out  (buf_ready),
        .out_valid_out (buf_valid),
        .out_data_out  (buf_data),
        .out_ready_in  (vol_ready_in)
    );

    assign smp_ready_out = buf_ready;
    assign vol_valid_out = buf_valid;
    assign vol_left_out = buf_data[2*SAMPLE_W-1:SAMPLE_W];
    assign vol_right_out = buf_data[SAMPLE_W-1:0];
    assign reg_rdata_out = s_reg.rdata;
    assign volume_sense_trial_out = s_reg.trial;
    assign volume_sense_hold_out = s_reg.hold;
    assign group_delay_out = s_reg.delay;
    assign max_rate_ksps_out = s_reg.ksps;
endmodule // dvs_volume_top

// [shared/dvs_pkg.sv]
// Purpose: constants and types for the digital volume soft-step block
// Assumes: 20 MHz system clock, page 0 register map only
// Notes:   gains are held in eighth-dB units internally
package dvs_pkg;
    // register offsets
    localparam logic [7:0] ADDR_SETTLED   = 8'h26;
    localparam logic [7:0] ADDR_STEP      = 8'h3f;
    localparam logic [7:0] ADDR_MUTE      = 8'h40;
    localparam logic [7:0] ADDR_GAIN_L    = 8'h41;
    localparam logic [7:0] ADDR_GAIN_R    = 8'h42;
    localparam logic [7:0] ADDR_PIN_CTRL  = 8'h74;
    localparam logic [7:0] ADDR_PIN_READ  = 8'h75;
    // reset values
    localparam logic [1:0] RST_STEP       = 2'h0;
    localparam logic [3:0] RST_MUTE       = 4'hc;
    localparam logic [7:0] RST_GAIN       = 8'h00;
    localparam logic [7:0] RST_PIN_CTRL   = 8'h00;
    localparam logic [6:0] RST_PIN_CODE   = 7'h00;
    // field positions
    localparam int SETTLED_L_BIT = 4;
    localparam int SETTLED_R_BIT = 0;
    localparam int MUTE_L_BIT    = 3;
    localparam int MUTE_R_BIT    = 2;
    localparam int PIN_EN_BIT    = 7;
    localparam int PIN_CLK_BIT   = 6;
    // stepping field codes
    localparam logic [1:0] STEP_NORMAL    = 2'h0;
    localparam logic [1:0] STEP_HALF      = 2'h1;
    // master field codes
    localparam logic [1:0] MASTER_FROM_L  = 2'h1;
    localparam logic [1:0] MASTER_FROM_R  = 2'h2;
    // gain encoding
    localparam logic signed [7:0] GAIN_MAX_HALF = 8'sh30;
    localparam logic [7:0] MUTE_SETTING   = 8'h80;
    localparam logic signed [9:0] MUTE_Q  = -10'sh200;
    localparam int Q_PER_OCT     = 48;
    localparam int Q_OFFSET      = 528;
    localparam int MANT_ONE      = 32768;
    localparam int MANT_SLOPE    = 683;
    localparam int SHIFT_BASE    = 26;
    // volume pin code map
    localparam logic [6:0] PIN_LIN_LAST   = 7'h5a;
    localparam logic [6:0] PIN_MUTE_CODE  = 7'h7f;
    localparam logic signed [7:0] PIN_TOP_HALF = 8'sh24;
    localparam logic signed [7:0] PIN_BRK_HALF = -8'sh38;
    localparam logic [6:0] PIN_BRK_CODE   = 7'h5b;
    // interpolation filters
    localparam logic [7:0] FILT_A_KSPS    = 8'h30;
    localparam logic [4:0] FILT_A_DELAY   = 5'h15;
    localparam logic [7:0] FILT_B_KSPS    = 8'h60;
    localparam logic [4:0] FILT_B_DELAY   = 5'h12;
    localparam logic [7:0] FILT_C_KSPS    = 8'hc0;
    localparam logic [4:0] FILT_C_DELAY   = 5'h0d;
    // timing
    localparam int SYS_CLK_PERIOD_NS = 50;
    localparam int SAR_CLK_PERIOD_NS = 1000;
    localparam int SAR_DIV_CYCLES    = SAR_CLK_PERIOD_NS / SYS_CLK_PERIOD_NS;
    localparam int RATE_BASE_TICKS   = 128;

    typedef enum logic [1:0] {SAR_IDLE, SAR_HOLD, SAR_CONV} dvs_sar_t;
endpackage

// [rtl/dvs_pair_buf.sv]
// Purpose: small in-order buffer with valid/ready on both sides
// Assumes: single clock, synchronous use of the released reset
// Notes:   head entry is always slot 0 so the output is a flop
`timescale 1ns/10ps
module dvs_pair_buf #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 2
) (
    input  wire logic             clk_in,
    input  wire logic             rst_n_in,
    input  wire logic             in_valid_in,
    input  wire logic [WIDTH-1:0] in_data_in,
    output logic                  in_ready_out,
    output logic                  out_valid_out,
    output logic [WIDTH-1:0]      out_data_out,
    input  wire logic             out_ready_in
);
    localparam int CW = $clog2(DEPTH + 1);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [CW-1:0]               cnt;
        logic                        room;
        logic                        valid;
    } dvs_buf_state_t;

    dvs_buf_state_t s_reg, s_next;

    always_comb begin
        logic push;
        logic pop;
        logic [CW-1:0] wr;
        push = 1'b0;
        pop = 1'b0;
        wr = '0;
        s_next = s_reg;
        push = in_valid_in & s_reg.room;
        pop = s_reg.valid & out_ready_in;
        if (pop) begin
            for (int i = 0; i < DEPTH - 1; i++) begin
                s_next.mem[i] = s_reg.mem[i+1];
            end
        end
        wr = s_reg.cnt - CW'(pop);
        if (push) begin
            s_next.mem[wr] = in_data_in;
        end
        s_next.cnt = s_reg.cnt + CW'(push) - CW'(pop);
        s_next.room = (s_next.cnt != CW'(DEPTH));
        s_next.valid = (s_next.cnt != '0);
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s_reg <= '0;
            s_reg.room <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    assign in_ready_out = s_reg.room;
    assign out_valid_out = s_reg.valid;
    assign out_data_out = s_reg.mem[0];
endmodule // dvs_pair_buf

// [testbench/dvs_volume_chk.sv]
// Purpose: port-level assertions for the volume block
// Assumes: registered outputs, reset released through two flops
// Notes:   live gates out the first edges, where outputs still hold reset values
`timescale 1ns/10ps
module dvs_volume_chk
    import dvs_pkg::*;
(
    input wire logic       clk_sys_in,
    input wire logic       reset_n_in,
    input wire logic       reg_rd_in,
    input wire logic [7:0] reg_rdata_out,
    input wire logic       smp_ready_out,
    input wire logic       vol_valid_out,
    input wire logic [15:0] vol_left_out,
    input wire logic [15:0] vol_right_out,
    input wire logic       vol_ready_in,
    input wire logic [6:0] volume_sense_trial_out,
    input wire logic       volume_sense_hold_out,
    input wire logic [1:0] interp_sel_in,
    input wire logic [4:0] group_delay_out,
    input wire logic [7:0] max_rate_ksps_out
);
    logic [1:0] settle_reg;
    logic       live;
    assign live = &settle_reg;
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) settle_reg <= 2'h0;
        else settle_reg <= settle_reg + 2'(!live);
    end
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!reset_n_in);
    a_filter_a_sel: assert property (live && interp_sel_in == 2'h0 |=>
        group_delay_out == FILT_A_DELAY && max_rate_ksps_out == FILT_A_KSPS) else $error("filter a figures wrong");
    a_filter_b_sel: assert property (live && interp_sel_in == 2'h1 |=>
        group_delay_out == FILT_B_DELAY && max_rate_ksps_out == FILT_B_KSPS) else $error("filter b figures wrong");
    a_filter_c_sel: assert property (live && interp_sel_in[1] |=>
        group_delay_out == FILT_C_DELAY && max_rate_ksps_out == FILT_C_KSPS) else $error("filter c figures wrong");
    a_out_word_hold: assert property (vol_valid_out && !vol_ready_in |=>
        vol_valid_out && $stable(vol_left_out) && $stable(vol_right_out)) else $error("stalled word changed");
    a_rdata_hold: assert property (live && !reg_rd_in |=> $stable(reg_rdata_out))
        else $error("read data moved without a read");
    a_trial_after_hold: assert property ($fell(volume_sense_hold_out) |->
        ##[0:20] volume_sense_trial_out == 7'h40) else $error("first trial code wrong");
    a_hold_ends: assert property ($rose(volume_sense_hold_out) |-> ##[1:1000] !volume_sense_hold_out)
        else $error("hold request stuck");
    a_ready_refill: assert property (!smp_ready_out && vol_valid_out && vol_ready_in |=> smp_ready_out)
        else $error("ready not back after drain");
endmodule // dvs_volume_chk
bind dvs_volume_top dvs_volume_chk u_chk (.clk_sys_in, .reset_n_in, .reg_rd_in, .reg_rdata_out, .smp_ready_out,
    .vol_valid_out, .vol_left_out, .vol_right_out, .vol_ready_in, .volume_sense_trial_out, .volume_sense_hold_out,
    .interp_sel_in, .group_delay_out, .max_rate_ksps_out);

// [testbench/dvs_pot_model.sv]
// Purpose: potentiometer plus comparator seen by the volume converter
// Assumes: pot level expressed as the code an ideal converter returns
// Notes:   level is frozen at hold so a mid-conversion change cannot mix codes
`timescale 1ns/10ps
module dvs_pot_model (
    input  wire logic       clk_in,
    input  wire logic [6:0] pot_code_in,
    input  wire logic [6:0] trial_in,
    input  wire logic       hold_in,
    output logic            cmp_out
);
    logic [6:0] held_reg = 7'h7f;
    always_ff @(posedge clk_in) if (hold_in) held_reg <= pot_code_in;
    assign cmp_out = (held_reg >= trial_in);
endmodule // dvs_pot_model

// [testbench/dvs_volume_top_tb_top.sv]
// Purpose: register-driven tests of gain, stepping, buffer and pin mode
// Assumes: 20 MHz clock that never stops, inputs driven on rising edge
// Notes:   outputs are captured by a monitor while downstream is ready
`timescale 1ns/10ps
module dvs_volume_top_tb_top;
    import dvs_pkg::*;
    logic        clk_sys_in = 1'b0;
    logic        reset_n_in = 1'b0;
    logic [7:0]  reg_addr_in = 8'h00;
    logic        reg_wr_in = 1'b0;
    logic [7:0]  reg_wdata_in = 8'h00;
    logic        reg_rd_in = 1'b0;
    logic [7:0]  reg_rdata_out;
    logic        smp_valid_in = 1'b0;
    logic [15:0] smp_left_in = 16'h0000;
    logic [15:0] smp_right_in = 16'h0000;
    logic        smp_ready_out;
    logic        vol_valid_out;
    logic [15:0] vol_left_out;
    logic [15:0] vol_right_out;
    logic        vol_ready_in = 1'b1;
    logic        cmp;
    logic [6:0]  trial;
    logic        hold;
    logic [1:0]  interp_sel_in = 2'h0;
    logic [4:0]  group_delay_out;
    logic [7:0]  max_rate_ksps_out;
    logic [6:0]  pot_code = 7'h0a;
    logic [15:0] last_l;
    logic [15:0] last_r;
    int          out_cnt = 0;
    int          num_errors = 0;
    int          checks = 0;
    // clock never stops, so stepping always completes
    always #25 clk_sys_in = ~clk_sys_in;
    dvs_volume_top u_dut (.clk_sys_in, .reset_n_in, .reg_addr_in, .reg_wr_in, .reg_wdata_in, .reg_rd_in,
        .reg_rdata_out, .smp_valid_in, .smp_left_in, .smp_right_in, .smp_ready_out, .vol_valid_out, .vol_left_out,
        .vol_right_out, .vol_ready_in, .volume_sense_cmp_in(cmp), .volume_sense_trial_out(trial),
        .volume_sense_hold_out(hold), .interp_sel_in, .group_delay_out, .max_rate_ksps_out);
    dvs_pot_model u_pot (.clk_in(clk_sys_in), .pot_code_in(pot_code), .trial_in(trial), .hold_in(hold),
        .cmp_out(cmp));
    always @(posedge clk_sys_in) if (vol_valid_out && vol_ready_in) begin
        last_l <= vol_left_out;
        last_r <= vol_right_out;
        out_cnt <= out_cnt + 1;
    end
    task automatic results();
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge clk_sys_in);
        reg_wr_in <= 1'b0;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_sys_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge clk_sys_in);
        reg_rd_in <= 1'b0;
        #1 chk({8'h00, reg_rdata_out}, {8'h00, exp});
    endtask
    task automatic send(input logic [15:0] l, input logic [15:0] r);
        int n;
        n = 0;
        @(posedge clk_sys_in);
        smp_valid_in <= 1'b1;
        smp_left_in <= l;
        smp_right_in <= r;
        @(negedge clk_sys_in);
        while (!smp_ready_out && n < 100) begin
            @(negedge clk_sys_in);
            n++;
        end
        @(posedge clk_sys_in);
        smp_valid_in <= 1'b0;
    endtask
    task automatic sendn(input int k);
        repeat (k) send(16'h0000, 16'h0000);
    endtask
    task automatic pair(input logic [7:0] mute, input logic [15:0] el, input logic [15:0] er);
        wr(ADDR_MUTE, mute);
        send(16'h1000, 16'h1000);
        repeat (3) @(posedge clk_sys_in);
        chk(last_l, el);
        chk(last_r, er);
    endtask
    function automatic logic [7:0] pin_gain(input int c);
        if (c == 127) return 8'h80;
        if (c <= 90) return 8'(36 - c);
        return 8'(-56 - 2 * (c - 91));
    endfunction
    logic [7:0] rst_a [7] = '{8'h3f, 8'h40, 8'h41, 8'h42, 8'h74, 8'h75, 8'h10};
    logic [7:0] rst_v [7] = '{8'h00, 8'h0c, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [4:0] dly_v [4] = '{5'h15, 5'h12, 5'h0d, 5'h0d};
    logic [7:0] rate_v [4] = '{8'h30, 8'h60, 8'hc0, 8'hc0};
    int pin_c [5] = '{10, 90, 91, 126, 127};
    initial begin
        repeat (6) @(posedge clk_sys_in);
        reset_n_in <= 1'b1;
        repeat (3) @(posedge clk_sys_in);
        foreach (rst_a[i]) rdc(rst_a[i], rst_v[i]);
        wr(ADDR_PIN_READ, 8'h55);
        rdc(ADDR_PIN_READ, 8'h00);
        wr(ADDR_GAIN_L, 8'h18);
        rdc(ADDR_GAIN_L, 8'h18);
        wr(ADDR_STEP, 8'h02);
        wr(ADDR_GAIN_L, 8'h00);
        wr(ADDR_GAIN_R, 8'h00);
        pair(8'h00, 16'h1000, 16'h1000);
        pair(8'h08, 16'h0000, 16'h1000);
        wr(ADDR_GAIN_R, 8'hf4);
        pair(8'h02, 16'h0800, 16'h0800);
        pair(8'h01, 16'h1000, 16'h1000);
        pair(8'h00, 16'h1000, 16'h0800);
        wr(ADDR_GAIN_R, 8'h00);
        sendn(1);
        rdc(ADDR_SETTLED, 8'h11);
        wr(ADDR_STEP, 8'h00);
        wr(ADDR_GAIN_L, 8'h02);
        sendn(7);
        rdc(ADDR_SETTLED, 8'h01);
        sendn(1);
        rdc(ADDR_SETTLED, 8'h11);
        wr(ADDR_STEP, 8'h01);
        wr(ADDR_GAIN_L, 8'h00);
        sendn(14);
        rdc(ADDR_SETTLED, 8'h01);
        sendn(2);
        rdc(ADDR_SETTLED, 8'h11);
        @(posedge clk_sys_in);
        vol_ready_in <= 1'b0;
        sendn(2);
        @(negedge clk_sys_in);
        chk({15'h0000, smp_ready_out}, 16'h0000);
        repeat (5) @(negedge clk_sys_in);
        chk({15'h0000, smp_ready_out}, 16'h0000);
        chk(16'(out_cnt), 16'h001e);
        @(posedge clk_sys_in);
        vol_ready_in <= 1'b1;
        repeat (5) @(posedge clk_sys_in);
        chk(16'(out_cnt), 16'h0020);
        for (int s = 0; s < 4; s++) begin
            @(posedge clk_sys_in);
            interp_sel_in <= 2'(s);
            repeat (2) @(posedge clk_sys_in);
            #1 chk({11'h000, group_delay_out}, {11'h000, dly_v[s]});
            chk({8'h00, max_rate_ksps_out}, {8'h00, rate_v[s]});
        end
        repeat (6000) @(posedge clk_sys_in);
        rdc(ADDR_PIN_READ, 8'h00);
        rdc(ADDR_GAIN_L, 8'h00);
        wr(ADDR_PIN_CTRL, 8'hc5);
        rdc(ADDR_PIN_CTRL, 8'hc5);
        wr(ADDR_PIN_CTRL, 8'h80);
        rdc(ADDR_PIN_CTRL, 8'h80);
        foreach (pin_c[i]) begin
            pot_code <= 7'(pin_c[i]);
            repeat (6000) @(posedge clk_sys_in);
            rdc(ADDR_PIN_READ, 8'(pin_c[i]));
            rdc(ADDR_GAIN_L, pin_gain(pin_c[i]));
            rdc(ADDR_GAIN_R, pin_gain(pin_c[i]));
        end
        results();
    end
    initial begin
        repeat (90000) @(posedge clk_sys_in);
        num_errors++;
        results();
    end
endmodule // dvs_volume_top_tb_top
